//--- pio_cfg.svh
// Constants for the parallel I/O port control block
`ifndef PIO_CFG_SVH
`define PIO_CFG_SVH

// ************************************************************
// Pin population
// ************************************************************
`define PIO_NPORT        3'd7
`define PIO_NPIN         56
// Ports A-F full, port G pins 0..4 two-way, pin 5 input only
`define PIO_IMPL_MASK    56'h3f_ffff_ffff_ffff
`define PIO_BIDIR_MASK   56'h1f_ffff_ffff_ffff
`define PIO_INONLY_MASK  56'h20_0000_0000_0000
`define PIO_OUTONLY_MASK 56'h00_0000_0000_0000

// ************************************************************
// Register map (byte addresses)
// ************************************************************
`define PIO_ADDR_W       12
`define PIO_PAGE_DATA    4'h0
`define PIO_PAGE_CTRL    4'h1
`define PIO_SEL_LATCH    1'b0
`define PIO_SEL_DIR      1'b1
`define PIO_SEL_PULL     2'h0
`define PIO_SEL_SLEW     2'h1
`define PIO_SEL_DRIVE    2'h2

// ************************************************************
// Reset values
// ************************************************************
`define PIO_LATCH_RST    56'h00_0000_0000_0000
`define PIO_DIR_RST      56'h00_0000_0000_0000
`define PIO_PULL_RST     56'h00_0000_0000_0000
`define PIO_SLEW_RST     `PIO_BIDIR_MASK
`define PIO_DRIVE_RST    56'h00_0000_0000_0000

`endif

//--- pio_pkg.sv
// Types for the parallel I/O port control block
`include "pio_cfg.svh"

package pio_pkg;

    typedef logic [`PIO_NPIN-1:0] pio_vec_t;

    typedef struct packed {
        pio_vec_t s1;
        pio_vec_t s2;
    } pio_sync_state_t;

    typedef struct packed {
        pio_vec_t    port_data_latch;
        pio_vec_t    pin_direction_bit;
        pio_vec_t    pin_pullup_enable_bit;
        pio_vec_t    pin_slew_enable_bit;
        pio_vec_t    pin_high_drive_bit;
        pio_vec_t    pad_out;
        pio_vec_t    pad_oe;
        pio_vec_t    pad_ie;
        pio_vec_t    pad_pullup;
        pio_vec_t    pad_slew;
        pio_vec_t    pad_high_drive;
        pio_vec_t    periph_in;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } pio_state_t;

endpackage : pio_pkg

//--- pio_sync.sv
// Two-stage synchroniser for the pad input levels
`timescale 1ns/1ns

module pio_sync
    import pio_pkg::*;
(
    input  wire logic     clock,
    input  wire logic     sys_rst,
    input  wire pio_vec_t async_in,
    output pio_vec_t      sync_out
);

    pio_sync_state_t state_q;
    pio_sync_state_t state_d;

    // First stage feeds only the second stage
    always_comb begin
        state_d    = state_q;
        state_d.s1 = async_in;
        state_d.s2 = state_q.s1;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign sync_out = state_q.s2;

endmodule : pio_sync

//--- pio_port_ctrl.sv
// Parallel I/O port control: pin arbitration, pad control, APB registers
//
// Behaviour
// - Seven ports: 53 two-way pins and one input-only pin.
// - An enabled shared peripheral overrides general-purpose I/O on its pin.
// - Reset: peripherals off, direction input, slew on, low drive, pull-up off.
// - Direction bit gates output buffer and selects data read source.
// - Input buffer always on except analog or output-only pins.
// - Shared digital function drives output enable; direction still picks read source.
// - Analog owner: both buffers off; input-direction data reads return 0.
// - Analog function beats alternate digital function on the same pin.
// - Pull-up enable turns pull-up on; forced off while pin outputs.
// - Pull-up forced off while analog function controls the pin.
// - Per-pin slew enable applies only while the pin outputs.
// - Per-pin drive select requests high drive on the pad.
// - Pull, slew, drive registers independent, in separate register page.
// - Data writes store all latch bits; output pins drive stored level.
// - Direction 1 enables driver, reads latch; direction 0 reads pin.
// - Reset clears data latches, nothing driven.
`timescale 1ns/1ns
`include "pio_cfg.svh"

module pio_port_ctrl
    import pio_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   sys_rst,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`PIO_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire pio_vec_t               pad_in,
    output pio_vec_t                    pad_out,
    output pio_vec_t                    pad_oe,
    output pio_vec_t                    pad_ie,
    output pio_vec_t                    pad_pullup,
    output pio_vec_t                    pad_slew,
    output pio_vec_t                    pad_high_drive,
    input  wire pio_vec_t               alt_dig_en,
    input  wire pio_vec_t               alt_dig_oe,
    input  wire pio_vec_t               alt_dig_out,
    input  wire pio_vec_t               analog_en,
    output pio_vec_t                    periph_in
);

    // ************************************************************
    // State and pad input synchroniser
    // ************************************************************
    pio_state_t state_q;
    pio_state_t state_d;
    pio_vec_t   pin_lvl;

    // Pin population masks as vectors, so each pin picks its own bit
    localparam pio_vec_t bidir_m   = `PIO_BIDIR_MASK;
    localparam pio_vec_t impl_m    = `PIO_IMPL_MASK;
    localparam pio_vec_t outonly_m = `PIO_OUTONLY_MASK;

    pio_sync u_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .async_in (pad_in),
        .sync_out (pin_lvl)
    );

    // ************************************************************
    // Per-pin arbitration
    // ************************************************************
    pio_vec_t oe_w;
    pio_vec_t out_w;
    pio_vec_t ie_w;
    pio_vec_t pull_w;
    pio_vec_t slew_w;
    pio_vec_t drive_w;
    pio_vec_t rd_w;

    genvar gi;
    generate
        for (gi = 0; gi < `PIO_NPIN; gi++) begin : g_pin
            logic ana;
            logic dig;
            logic two_way;
            assign two_way = bidir_m[gi];
            // Analog wins over digital sharing
            assign ana = analog_en[gi];
            assign dig = alt_dig_en[gi] & ~ana;
            assign oe_w[gi] = two_way & ~ana &
                              (dig ? alt_dig_oe[gi] : state_q.pin_direction_bit[gi]);
            assign out_w[gi] = dig ? alt_dig_out[gi] : state_q.port_data_latch[gi];
            assign ie_w[gi] = ~ana & ~outonly_m[gi] & impl_m[gi];
            assign pull_w[gi] = state_q.pin_pullup_enable_bit[gi] & ~oe_w[gi] & ~ana;
            assign slew_w[gi] = state_q.pin_slew_enable_bit[gi] & oe_w[gi];
            assign drive_w[gi] = state_q.pin_high_drive_bit[gi] & two_way;
            // Direction picks the read source even under a digital owner
            assign rd_w[gi] = state_q.pin_direction_bit[gi] ?
                              state_q.port_data_latch[gi] : (pin_lvl[gi] & ie_w[gi]);
        end
    endgenerate

    // ************************************************************
    // APB decode
    // ************************************************************
    logic [3:0] page;
    logic [2:0] port;
    logic [5:0] base;
    logic       sel_dir;
    logic [1:0] sel_ctl;
    logic       hit;
    logic       access;
    logic [7:0] wbyte;

    // Data and direction in page 0, pad controls in their own page
    always_comb begin
        page    = paddr[11:8];
        sel_dir = paddr[2];
        sel_ctl = paddr[3:2];
        port    = (page == `PIO_PAGE_DATA) ? paddr[5:3] : paddr[6:4];
        base    = {port, 3'b000};
        hit     = 1'b0;
        if (paddr[1:0] == 2'b00 && port < `PIO_NPORT) begin
            if (page == `PIO_PAGE_DATA && paddr[7:6] == 2'b00) begin
                hit = 1'b1;
            end else if (page == `PIO_PAGE_CTRL && paddr[7] == 1'b0 &&
                         sel_ctl != 2'h3) begin
                hit = 1'b1;
            end
        end
        access = psel & penable & ~state_q.pready;
        wbyte  = pwdata[7:0];
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        state_d         = state_q;
        state_d.pready  = 1'b0;
        state_d.pslverr = 1'b0;
        if (access) begin
            state_d.pready  = 1'b1;
            state_d.pslverr = ~hit;
            state_d.prdata  = 32'h0000_0000;
            if (hit && pwrite && pstrb[0]) begin
                if (page == `PIO_PAGE_DATA) begin
                    if (sel_dir == `PIO_SEL_LATCH) begin
                        // All bits latch regardless of direction
                        state_d.port_data_latch[base +: 8] =
                            wbyte & impl_m[base +: 8];
                    end else begin
                        state_d.pin_direction_bit[base +: 8] =
                            wbyte & bidir_m[base +: 8];
                    end
                end else begin
                    case (sel_ctl)
                        `PIO_SEL_PULL: begin
                            state_d.pin_pullup_enable_bit[base +: 8] =
                                wbyte & impl_m[base +: 8];
                        end
                        `PIO_SEL_SLEW: begin
                            state_d.pin_slew_enable_bit[base +: 8] =
                                wbyte & bidir_m[base +: 8];
                        end
                        `PIO_SEL_DRIVE: begin
                            state_d.pin_high_drive_bit[base +: 8] =
                                wbyte & bidir_m[base +: 8];
                        end
                        default: begin
                        end
                    endcase
                end
            end else if (hit && !pwrite) begin
                if (page == `PIO_PAGE_DATA) begin
                    state_d.prdata[7:0] = (sel_dir == `PIO_SEL_LATCH) ?
                        rd_w[base +: 8] : state_q.pin_direction_bit[base +: 8];
                end else begin
                    case (sel_ctl)
                        `PIO_SEL_PULL:  state_d.prdata[7:0] = state_q.pin_pullup_enable_bit[base +: 8];
                        `PIO_SEL_SLEW:  state_d.prdata[7:0] = state_q.pin_slew_enable_bit[base +: 8];
                        `PIO_SEL_DRIVE: state_d.prdata[7:0] = state_q.pin_high_drive_bit[base +: 8];
                        default:        state_d.prdata[7:0] = 8'h00;
                    endcase
                end
            end
        end
        // Pad controls registered so every pin sees a glitch-free level
        state_d.pad_oe         = oe_w;
        state_d.pad_out        = out_w & oe_w;
        state_d.pad_ie         = ie_w;
        state_d.pad_pullup     = pull_w;
        state_d.pad_slew       = slew_w;
        state_d.pad_high_drive = drive_w;
        state_d.periph_in      = pin_lvl & ie_w;
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_q                       <= '0;
            state_q.port_data_latch       <= `PIO_LATCH_RST;
            state_q.pin_direction_bit     <= `PIO_DIR_RST;
            state_q.pin_pullup_enable_bit <= `PIO_PULL_RST;
            state_q.pin_slew_enable_bit   <= `PIO_SLEW_RST;
            state_q.pin_high_drive_bit    <= `PIO_DRIVE_RST;
        end else begin
            state_q <= state_d;
        end
    end

    assign prdata         = state_q.prdata;
    assign pready         = state_q.pready;
    assign pslverr        = state_q.pslverr;
    assign pad_out        = state_q.pad_out;
    assign pad_oe         = state_q.pad_oe;
    assign pad_ie         = state_q.pad_ie;
    assign pad_pullup     = state_q.pad_pullup;
    assign pad_slew       = state_q.pad_slew;
    assign pad_high_drive = state_q.pad_high_drive;
    assign periph_in      = state_q.periph_in;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence wr_latch_a_s;
        access && pwrite && pstrb[0] && paddr == 12'h000;
    endsequence

    sequence rd_latch_a_s;
        access && !pwrite && paddr == 12'h000;
    endsequence

    sequence wr_ctrl_s;
        access && pwrite && page == `PIO_PAGE_CTRL;
    endsequence

    reset_defaults_a: assert property (
        $past(sys_rst) |-> state_q.pin_slew_enable_bit == `PIO_SLEW_RST &&
            state_q.pin_direction_bit == 56'h0 && state_q.pin_pullup_enable_bit == 56'h0 &&
            state_q.pin_high_drive_bit == 56'h0 && state_q.port_data_latch == 56'h0)
        else $error("reset values wrong");

    reset_no_drive_a: assert property (
        $past(sys_rst) |=> pad_oe == 56'h0)
        else $error("pad driven after reset");

    alt_owns_oe_a: assert property (
        pad_oe == ($past(((alt_dig_en & alt_dig_oe) |
            (~alt_dig_en & state_q.pin_direction_bit)) & ~analog_en) & `PIO_BIDIR_MASK))
        else $error("output enable owner wrong");

    analog_bufs_off_a: assert property (
        ((pad_oe | pad_ie | pad_pullup) & $past(analog_en)) == 56'h0)
        else $error("analog pin buffer on");

    analog_wins_a: assert property (
        (analog_en & alt_dig_en & alt_dig_oe) != 56'h0 |=>
            (pad_oe & $past(analog_en)) == 56'h0)
        else $error("digital beat analog");

    input_buf_a: assert property (
        !$past(sys_rst) |-> pad_ie == $past(~analog_en & ~`PIO_OUTONLY_MASK & `PIO_IMPL_MASK))
        else $error("input buffer state wrong");

    pull_off_out_a: assert property (
        (pad_pullup & pad_oe) == 56'h0 &&
        pad_pullup == ($past(state_q.pin_pullup_enable_bit & ~analog_en) & ~pad_oe))
        else $error("pull-up while output");

    slew_out_only_a: assert property (
        pad_slew == ($past(state_q.pin_slew_enable_bit) & pad_oe))
        else $error("slew on input pin");

    high_drive_a: assert property (
        pad_high_drive == ($past(state_q.pin_high_drive_bit) & `PIO_BIDIR_MASK))
        else $error("drive select lost");

    latch_write_a: assert property (
        wr_latch_a_s |=> state_q.port_data_latch[7:0] == $past(pwdata[7:0]) ##1
            (pad_out[7:0] & ~$past(alt_dig_en[7:0])) ==
            (state_q.port_data_latch[7:0] & pad_oe[7:0] & ~$past(alt_dig_en[7:0])))
        else $error("latch write lost");

    read_source_a: assert property (
        rd_latch_a_s |=> prdata[7:0] == $past((state_q.pin_direction_bit[7:0] &
            state_q.port_data_latch[7:0]) | (~state_q.pin_direction_bit[7:0] &
            pin_lvl[7:0] & ie_w[7:0])) && pready)
        else $error("read source wrong");

    ctrl_indep_a: assert property (
        wr_ctrl_s |=> $stable(state_q.port_data_latch) && $stable(state_q.pin_direction_bit))
        else $error("control write hit data page");

    unimpl_zero_a: assert property (
        (state_q.pin_direction_bit & ~`PIO_BIDIR_MASK) == 56'h0 &&
        (state_q.port_data_latch & ~`PIO_IMPL_MASK) == 56'h0 &&
        (pad_oe & ~`PIO_BIDIR_MASK) == 56'h0)
        else $error("missing pin holds state");

    apb_answer_a: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer timing wrong");

    sequence rd_analog_s;
        rd_latch_a_s ##0 (analog_en[7:0] & ~state_q.pin_direction_bit[7:0]) != 8'h00;
    endsequence

    analog_read_zero_a: assert property (
        rd_analog_s |=> (prdata[7:0] & $past(analog_en[7:0] & ~state_q.pin_direction_bit[7:0])) == 8'h00)
        else $error("analog pin read not zero");

    periph_gate_a: assert property (
        periph_in == ($past(pin_lvl) & pad_ie))
        else $error("peripheral input not gated");

    unmapped_err_a: assert property (
        access && paddr[1:0] != 2'b00 |=> pready && pslverr && prdata == 32'h0000_0000)
        else $error("misaligned access not refused");

    digital_data_a: assert property (
        pad_out == ($past((alt_dig_en & ~analog_en & alt_dig_out) |
            (~alt_dig_en & state_q.port_data_latch)) & pad_oe))
        else $error("pad data from wrong owner");

    data_page_indep_a: assert property (
        access && pwrite && page == `PIO_PAGE_DATA |=> $stable(state_q.pin_pullup_enable_bit) &&
            $stable(state_q.pin_slew_enable_bit) && $stable(state_q.pin_high_drive_bit))
        else $error("data write hit control page");

    direction_drive_a: assert property (
        (pad_oe & ~$past(alt_dig_en | analog_en)) ==
            ($past(state_q.pin_direction_bit & ~(alt_dig_en | analog_en)) & `PIO_BIDIR_MASK))
        else $error("direction does not drive pad");

endmodule : pio_port_ctrl

//--- pio_pad_model.sv
// Behavioural pad ring that resolves each pin level from all drivers
`timescale 1ns/1ns

module pio_pad_model
    import pio_pkg::*;
(
    input  wire logic     clock,
    input  wire pio_vec_t pad_out,
    input  wire pio_vec_t pad_oe,
    input  wire pio_vec_t pad_pullup,
    input  wire pio_vec_t ext_val,
    input  wire pio_vec_t ext_en,
    output pio_vec_t      pad_in
);
    // ************************************************************
    // Pin resolution
    // ************************************************************
    pio_vec_t float_q = 56'h55_5555_5555_5555;

    // Undriven pins wander, so a missing pull never reads as a stable level
    always @(posedge clock) begin
        float_q <= ~float_q;
    end

    always_comb begin
        pad_in = (pad_oe & pad_out)
               | (~pad_oe & ext_en & ext_val)
               | (~pad_oe & ~ext_en & pad_pullup)
               | (~pad_oe & ~ext_en & ~pad_pullup & float_q);
    end
endmodule : pio_pad_model

//--- test_pio_port_ctrl.sv
// Self-checking bench for the parallel I/O port control block
`timescale 1ns/1ns
`include "pio_cfg.svh"

module test_pio_port_ctrl
    import pio_pkg::*;
;
    logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [32:0] q[$];
    logic [32:0] nq;
    pio_vec_t    pad_in, pad_out, pad_oe, pad_ie, pad_pullup, pad_slew, pad_high_drive, periph_in;
    pio_vec_t    alt_dig_en, alt_dig_oe, alt_dig_out, analog_en, ext_val, ext_en;
    pio_vec_t    ana, dig, e_oe, e_out, e_ie, e_pu, e_wire, e_rd;
    pio_vec_t    m[5];
    int          n_fail, n_tests, seed, p, i;

    pio_port_ctrl i_pio_port_ctrl (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_ie(pad_ie),
        .pad_pullup(pad_pullup), .pad_slew(pad_slew), .pad_high_drive(pad_high_drive),
        .alt_dig_en(alt_dig_en), .alt_dig_oe(alt_dig_oe), .alt_dig_out(alt_dig_out),
        .analog_en(analog_en), .periph_in(periph_in));

    pio_pad_model i_pio_pad_model (.clock(clock), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup(pad_pullup), .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));

    // ************************************************************
    // Expected pin behaviour from the register model
    // ************************************************************
    assign ana    = analog_en & `PIO_IMPL_MASK;
    assign dig    = alt_dig_en & ~ana & `PIO_IMPL_MASK;
    assign e_oe   = ((m[1] & ~dig) | (alt_dig_oe & dig)) & ~ana & `PIO_BIDIR_MASK;
    assign e_out  = (dig & alt_dig_out) | (~dig & m[0]);
    assign e_ie   = `PIO_IMPL_MASK & ~ana & ~`PIO_OUTONLY_MASK;
    assign e_pu   = m[2] & ~e_oe & ~ana;
    assign e_wire = (e_oe & e_out) | (~e_oe & ext_en & ext_val) | (~e_oe & ~ext_en & e_pu);
    assign e_rd   = (m[0] & m[1]) | (e_wire & ~m[1] & e_ie);

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task results;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results

    function automatic pio_vec_t rv();
        logic [63:0] r;
        r = {$random(seed), $random(seed)};
        return r[55:0];
    endfunction : rv

    function automatic logic [11:0] adr(input int k, input int pt);
        return (k < 2) ? 12'(8 * pt + 4 * k) : 12'(256 + 16 * pt + 4 * (k - 2));
    endfunction : adr

    // ************************************************************
    // APB master: result notes go to the queue, monitor compares
    // ************************************************************
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                       input logic [32:0] exp);
        logic [31:0] r;
        q.push_back(exp);
        r = $random(seed);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {r[31:8], d};
        pstrb   <= s;
        @(posedge clock);
        penable <= 1'b1;
        // Only pready or the watchdog ends a wait for the answer
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    always @(posedge clock) begin
        if (psel && penable && pready === 1'b1) begin
            nq = q.pop_front();
            if (pwrite) check(pslverr, nq[32]);
            else check({pslverr, prdata}, nq);
        end
    end

    task automatic wreg(input int k, input int pt, input logic [7:0] d);
        pio_vec_t t;
        t = (k == 1 || k > 2) ? `PIO_BIDIR_MASK : `PIO_IMPL_MASK;
        apb(1'b1, adr(k, pt), d, 4'h1, 33'h0_0000_0000);
        m[k][8*pt +: 8] = d & t[8*pt +: 8];
    endtask : wreg

    task automatic rd_port(input int pt);
        pio_vec_t t;
        for (int k = 0; k < 5; k++) begin
            t = (k == 0) ? e_rd : m[k];
            apb(1'b0, adr(k, pt), 8'h00, 4'h0, {25'h000_0000, t[8*pt +: 8]});
        end
    endtask : rd_port

    task chk_pads;
        repeat (5) @(posedge clock);
        @(negedge clock);
        check(pad_oe, e_oe);
        check(pad_out & e_oe, e_out & e_oe);
        check(pad_ie, e_ie);
        check(pad_pullup, e_pu);
        check(pad_slew, m[3] & e_oe);
        check(pad_high_drive, m[4]);
        check(periph_in, e_wire & e_ie);
    endtask : chk_pads

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        seed = 32'h8531;
        {sys_rst, psel, penable, pwrite, paddr, pwdata, pstrb} = {1'b1, 51'h0};
        {alt_dig_en, alt_dig_oe, alt_dig_out, analog_en} = {4{56'h00_0000_0000_0000}};
        m = '{`PIO_LATCH_RST, `PIO_DIR_RST, `PIO_PULL_RST, `PIO_SLEW_RST, `PIO_DRIVE_RST};
        ext_en  = `PIO_IMPL_MASK;
        ext_val = rv();
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        chk_pads;
        for (p = 0; p < 7; p++) rd_port(p);
        apb(1'b0, 12'h002, 8'h00, 4'h0, 33'h1_0000_0000);
        apb(1'b1, 12'h10c, 8'hff, 4'h1, 33'h1_0000_0000);
        apb(1'b1, 12'h000, 8'hff, 4'h0, 33'h0_0000_0000);
        for (p = 0; p < 7; p++) wreg(3, p, 8'h55);
        wreg(0, 2, 8'ha5);
        wreg(1, 2, 8'hff);
        wreg(1, 6, 8'hff);
        chk_pads;
        for (p = 0; p < 7; p++) rd_port(p);
        // Unconnected port pins held up by their pull-ups
        ext_en[15:8] <= 8'h00;
        wreg(2, 1, 8'hff);
        chk_pads;
        rd_port(1);
        analog_en[15] <= 1'b1;
        wreg(1, 1, 8'h0f);
        chk_pads;
        rd_port(1);
        ext_en <= `PIO_IMPL_MASK;
        for (i = 0; i < 40; i++) begin
            analog_en   <= rv() & rv() & rv();
            alt_dig_en  <= rv() & rv();
            alt_dig_oe  <= rv();
            alt_dig_out <= rv();
            ext_val     <= rv();
            p = {$random(seed)} % 7;
            wreg({$random(seed)} % 5, p, 8'($random(seed)));
            chk_pads;
            rd_port(p);
        end
        results;
    end

    initial begin
        #200000;
        n_fail++;
        results;
    end
endmodule : test_pio_port_ctrl
